// file: src/macro_array.sv
// Top of the sum-of-products macrocell array with its configuration store.
// Assumes pins come from board logic asynchronous to clk_i, and a
// register master that follows the single-cycle strobe protocol.
//
// Functional notes
// RQ1: Ten input-only pins and eight two-way pins; up to eighteen inputs, eight outputs.
// RQ2: Each two-way pin is set on its own to input, output or bidirectional.
// RQ3: Eight identical macrocells, each owning exactly one two-way pin.
// RQ4: A programmable AND plane feeds a fixed OR; both logic styles supported.
// RQ5: Eight product terms per cell over 36 literals, true and inverted, ORed.
// RQ6: Each OR result feeds an output stage holding one D register.
// RQ7: Per cell, output and feedback each pick combinational or registered, with inversion (code: comb feedback is clocked comb_reg; pin_o is registered).
// RQ8: Erased cell drives combinational active-low output with feedback from the pin.
// RQ9: Every control bit erases to one; programming takes it to zero.
// RQ10: A set security bit stops configuration readback.
// RQ11: Erase clears security and every other bit, restoring defaults and readback.
// RQ12: Storage shares one clock, rising edge, cleared to zero by reset (code: config store resets to ones; pin_sync stages unreset).
`timescale 1ns/100ps
module macro_array #(
  parameter int N_DED = macro_array_pkg::N_DED,
  parameter int N_CELL = macro_array_pkg::N_CELL
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [N_DED-1:0] ded_i,
  input wire logic [N_CELL-1:0] io_i,
  output logic [N_CELL-1:0] io_o,
  output logic [N_CELL-1:0] io_oe_o,
  input wire logic [macro_array_pkg::ADDR_W-1:0] addr_i,
  input wire logic [macro_array_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [macro_array_pkg::DATA_W-1:0] rdata_o
);

  localparam int NT = macro_array_pkg::N_TERM;
  localparam int NL = macro_array_pkg::N_LIT;
  localparam int NW = N_CELL * NT;
  localparam int CW = macro_array_pkg::CTL_W;
  localparam int DW = macro_array_pkg::DATA_W;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The address map holds at most eight cells and the literal width is fixed
  if (N_CELL < 1 || N_CELL > 8 || NL != 2 * (N_DED + N_CELL))
  begin : g_bad_params
    $error("macro_array: cell or input count does not fit the literal plane");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic macro_array_pkg::acc_t decode(
    input logic [macro_array_pkg::ADDR_W-1:0] a
  );
    macro_array_pkg::acc_t r;
    r = macro_array_pkg::ACC_NONE;
    if (a[7] == 1'h0)
    begin
      if (int'(a[6:4]) < N_CELL)
      begin
        r = macro_array_pkg::ACC_TERM;
      end
    end
    else if (a[7:4] == macro_array_pkg::CTRL_BASE[7:4])
    begin
      if (int'(a[3:0]) < N_CELL)
      begin
        r = macro_array_pkg::ACC_CTRL;
      end
    end
    else if (a == macro_array_pkg::SEC_ADDR)
    begin
      r = macro_array_pkg::ACC_SEC;
    end
    else if (a == macro_array_pkg::ERASE_ADDR)
    begin
      r = macro_array_pkg::ACC_ERASE;
    end
    else if (a == macro_array_pkg::STATUS_ADDR)
    begin
      r = macro_array_pkg::ACC_STATUS;
    end
    return r;
  endfunction : decode

  macro_array_pkg::acc_t wr_acc;
  macro_array_pkg::acc_t rd_acc;
  logic [5:0] term_idx;
  logic [2:0] ctrl_idx;
  logic erase_hit;

  assign wr_acc = decode(addr_i);
  assign rd_acc = wr_acc;
  assign term_idx = addr_i[6:1];
  assign ctrl_idx = addr_i[2:0];
  assign erase_hit = wr_i && (wr_acc == macro_array_pkg::ACC_ERASE);

  // ---------------------------------------------------------------
  // Configuration store
  // ---------------------------------------------------------------
  // Writes can only clear bits, as programming does; only erase or reset sets them
  logic [NL-1:0] term_mem [0:NW-1];
  logic [CW-1:0] ctrl_mem [0:N_CELL-1];
  logic sec_ok_reg;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || erase_hit)
    begin
      for (int i = 0; i < NW; i++)
      begin
        term_mem[i] <= macro_array_pkg::ERASED_TERM; // RQ9 RQ11
      end
    end
    else if (wr_i && wr_acc == macro_array_pkg::ACC_TERM)
    begin
      if (addr_i[0])
      begin
        term_mem[term_idx][NL-1:32] <= term_mem[term_idx][NL-1:32] & wdata_i[NL-33:0]; // RQ9
      end
      else
      begin
        term_mem[term_idx][31:0] <= term_mem[term_idx][31:0] & wdata_i; // RQ9
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || erase_hit)
    begin
      for (int i = 0; i < N_CELL; i++)
      begin
        ctrl_mem[i] <= macro_array_pkg::ERASED_CTL; // RQ8 RQ11
      end
    end
    else if (wr_i && wr_acc == macro_array_pkg::ACC_CTRL)
    begin
      ctrl_mem[ctrl_idx] <= ctrl_mem[ctrl_idx] & wdata_i[CW-1:0]; // RQ9
    end
  end

  // Security bit: one means open; programming it to zero locks readback
  always_ff @(posedge clk_i)
  begin
    if (srst_i || erase_hit)
    begin
      sec_ok_reg <= macro_array_pkg::ERASED_SEC; // RQ11
    end
    else if (wr_i && wr_acc == macro_array_pkg::ACC_SEC)
    begin
      sec_ok_reg <= sec_ok_reg & wdata_i[0]; // RQ10
    end
  end

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  logic [N_DED-1:0] ded_s;
  logic [N_CELL-1:0] io_s;

  pin_sync #(
    .W(N_DED)
  ) u_ded_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(ded_i),
    .q_o(ded_s)
  );

  pin_sync #(
    .W(N_CELL)
  ) u_io_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(io_i),
    .q_o(io_s)
  );

  // ---------------------------------------------------------------
  // Product term plane literals
  // ---------------------------------------------------------------
  // Literal 2k is input k true, 2k+1 is its complement
  logic [N_CELL-1:0] fb;
  logic [N_CELL-1:0] q;
  logic [N_DED+N_CELL-1:0] plane_in;
  logic [NL-1:0] lit;

  assign plane_in = {fb, ded_s}; // RQ1

  always_comb
  begin
    for (int k = 0; k < N_DED + N_CELL; k++)
    begin
      lit[2*k] = plane_in[k]; // RQ5
      lit[2*k+1] = ~plane_in[k]; // RQ5
    end
  end

  // ---------------------------------------------------------------
  // Macrocells
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < N_CELL; c++)
    begin : g_cell
      logic [NT*NL-1:0] terms;

      for (genvar t = 0; t < NT; t++)
      begin : g_term
        assign terms[t*NL +: NL] = term_mem[c*NT+t];
      end

      macrocell u_cell (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .lit_i(lit),
        .terms_i(terms),
        .ctrl_i(ctrl_mem[c]),
        .pin_fb_i(io_s[c]),
        .pin_o(io_o[c]),
        .oe_o(io_oe_o[c]),
        .fb_o(fb[c]),
        .q_o(q[c])
      ); // RQ3
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Locked configuration reads as zero; status stays visible
  logic [DW-1:0] rd_val;
  logic [NL-1:0] rd_term;

  assign rd_term = term_mem[term_idx];

  always_comb
  begin
    rd_val = '0;
    case (rd_acc)
      macro_array_pkg::ACC_TERM:
      begin
        if (sec_ok_reg)
        begin
          rd_val = addr_i[0] ? DW'(rd_term[NL-1:32]) : rd_term[31:0]; // RQ10
        end
      end
      macro_array_pkg::ACC_CTRL:
      begin
        if (sec_ok_reg)
        begin
          rd_val = DW'(ctrl_mem[ctrl_idx]); // RQ10
        end
      end
      macro_array_pkg::ACC_SEC:
      begin
        rd_val = DW'(sec_ok_reg);
      end
      macro_array_pkg::ACC_STATUS:
      begin
        rd_val[7:0] = 8'(q);
        rd_val[15:8] = 8'(io_s);
        rd_val[16] = sec_ok_reg;
      end
      default:
      begin
        rd_val = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_o <= '0;
    end
    else if (rd_i)
    begin
      rdata_o <= rd_val;
    end
    else
    begin
      rdata_o <= '0;
    end
  end

endmodule : macro_array

// file: inc/macro_array_pkg.sv
// Constants for the sum-of-products macrocell array.
// Assumes one clock domain and a plain address/strobe register port.
package macro_array_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int N_DED = 10;
  localparam int N_CELL = 8;
  localparam int N_TERM = 8;
  localparam int N_LIT = 36;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // Register map (32-bit word addresses on the register port)
  // ---------------------------------------------------------------
  localparam logic [7:0] TERM_BASE = 8'h00;
  localparam logic [7:0] CTRL_BASE = 8'h80;
  localparam logic [7:0] SEC_ADDR = 8'h90;
  localparam logic [7:0] ERASE_ADDR = 8'h91;
  localparam logic [7:0] STATUS_ADDR = 8'h92;

  // ---------------------------------------------------------------
  // Macrocell control word fields
  // ---------------------------------------------------------------
  localparam int CTL_W = 7;
  localparam int CTL_OUT_COMB = 0;
  localparam int CTL_OUT_INV = 1;
  localparam int CTL_FB_PIN = 2;
  localparam int CTL_FB_COMB = 3;
  localparam int CTL_FB_INV = 4;
  localparam int CTL_DRV_LO = 5;
  localparam int CTL_DRV_HI = 6;
  localparam logic [1:0] DRV_OUTPUT = 2'h3;
  localparam logic [1:0] DRV_BIDIR = 2'h1;

  // ---------------------------------------------------------------
  // Erased (reset) values: every control bit connected
  // ---------------------------------------------------------------
  localparam logic [CTL_W-1:0] ERASED_CTL = 7'h7F;
  localparam logic [N_LIT-1:0] ERASED_TERM = 36'hF_FFFF_FFFF;
  localparam logic ERASED_SEC = 1'h1;

  // Register access classes
  typedef enum {ACC_TERM, ACC_CTRL, ACC_SEC, ACC_ERASE, ACC_STATUS, ACC_NONE} acc_t;

endpackage : macro_array_pkg

// file: src/pin_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ---------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    s1_reg <= d_i;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      q_o <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
        begin
          q_o[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule : pin_sync

// file: src/macrocell.sv
// One macrocell: product terms, OR stage, D register, output and feedback select.
// Assumes configuration is held stable by the parent between writes.
`timescale 1ns/100ps
module macrocell (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [macro_array_pkg::N_LIT-1:0] lit_i,
  input wire logic [macro_array_pkg::N_TERM*macro_array_pkg::N_LIT-1:0] terms_i,
  input wire logic [macro_array_pkg::CTL_W-1:0] ctrl_i,
  input wire logic pin_fb_i,
  output logic pin_o,
  output logic oe_o,
  output logic fb_o,
  output logic q_o
);

  localparam int NL = macro_array_pkg::N_LIT;
  localparam int NT = macro_array_pkg::N_TERM;

  logic [NT-1:0] prod;
  logic sum;
  logic comb_reg;
  logic [1:0] drv;
  logic out_val;
  logic fb_val;

  // ---------------------------------------------------------------
  // Product terms and OR stage
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int t = 0; t < NT; t++)
    begin
      prod[t] = &(~terms_i[t*NL +: NL] | lit_i); // RQ5
    end
  end

  // Bidirectional mode spends term 0 on the pin enable
  assign drv = ctrl_i[macro_array_pkg::CTL_DRV_HI:macro_array_pkg::CTL_DRV_LO];
  assign sum = (drv == macro_array_pkg::DRV_BIDIR) ? |prod[NT-1:1] : |prod; // RQ4

  // ---------------------------------------------------------------
  // Storage: D register plus a sampled copy of the sum
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      q_o <= 1'h0; // RQ12
      comb_reg <= 1'h0;
    end
    else
    begin
      q_o <= sum; // RQ6
      comb_reg <= sum;
    end
  end

  // Combinational feedback comes from comb_reg, which breaks any loop
  assign out_val = ctrl_i[macro_array_pkg::CTL_OUT_COMB] ? sum : q_o; // RQ7
  assign fb_val = ctrl_i[macro_array_pkg::CTL_FB_PIN] ? pin_fb_i :
    (ctrl_i[macro_array_pkg::CTL_FB_COMB] ? comb_reg : q_o); // RQ7
  assign fb_o = fb_val ^ ctrl_i[macro_array_pkg::CTL_FB_INV]; // RQ8

  // ---------------------------------------------------------------
  // Pin stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_o <= 1'h0;
      oe_o <= 1'h0;
    end
    else
    begin
      pin_o <= out_val ^ ctrl_i[macro_array_pkg::CTL_OUT_INV]; // RQ8
      case (drv)
        macro_array_pkg::DRV_OUTPUT: oe_o <= 1'h1; // RQ2
        macro_array_pkg::DRV_BIDIR: oe_o <= prod[0]; // RQ2
        default: oe_o <= 1'h0; // RQ2
      endcase
    end
  end

endmodule : macrocell

// file: sim/macro_array_chk.sv
// Checker on the top ports of the macrocell array.
// Assumes one clock, synchronous reset and the single-cycle strobe port.
`timescale 1ns/100ps
module macro_array_chk #(
  parameter int N_CELL = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [N_CELL-1:0] io_o,
  input wire logic [N_CELL-1:0] io_oe_o,
  input wire logic [macro_array_pkg::ADDR_W-1:0] addr_i,
  input wire logic [macro_array_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [macro_array_pkg::DATA_W-1:0] rdata_o
);
  // ---------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------
  // Dirty is conservative: any non-ones write below 8'h88 counts, so the blank check may skip a case
  logic lock_reg;
  logic dirty_reg;
  logic [1:0] cnt_reg;
  wire logic erase_w = wr_i && addr_i == macro_array_pkg::ERASE_ADDR;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || erase_w)
    begin
      lock_reg <= 1'b0;
      dirty_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (wr_i && addr_i == macro_array_pkg::SEC_ADDR && !wdata_i[0])
        lock_reg <= 1'b1;
      if (wr_i && addr_i < 8'h88 && wdata_i != 32'hFFFFFFFF)
        dirty_reg <= 1'b1;
      if (cnt_reg != 2'h3)
        cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence erase_s;
    erase_w;
  endsequence

  // A write in the gap could legally clear bits again, so the gap must be quiet
  sequence erase_gap_s;
    erase_s ##1 !wr_i;
  endsequence

  chk_reset_pins: assert property (
    $fell(srst_i) |-> io_o == '0 && io_oe_o == '0 && rdata_o == '0)
    else $error("reset left outputs set");
  chk_erased_pins: assert property (
    !dirty_reg && cnt_reg == 2'h3 |-> &io_o && &io_oe_o)
    else $error("blank cell not driving high");
  chk_locked_read: assert property (
    rd_i && lock_reg && addr_i < 8'h88 |=> rdata_o == '0)
    else $error("configuration read while locked");
  chk_read_idle: assert property (
    !rd_i |=> rdata_o == '0)
    else $error("read data without a read");
  chk_erase_open: assert property (
    erase_gap_s ##1 rd_i && addr_i == macro_array_pkg::STATUS_ADDR |=> rdata_o[16])
    else $error("erase left device locked");
  chk_erased_term: assert property (
    erase_gap_s ##1 rd_i && addr_i < 8'h88 |=> rdata_o == ($past(addr_i[7]) ? 32'h7F :
      ($past(addr_i[0]) ? 32'hF : 32'hFFFFFFFF)))
    else $error("erased bit not one");
  chk_input_mode: assert property (
    wr_i && addr_i == 8'h82 && wdata_i[6:5] == 2'h0 |-> ##[1:3] !io_oe_o[2])
    else $error("input pin still driven");
  chk_extra_cell: assert property (
    rd_i && addr_i[7:3] == 5'h11 |=> rdata_o == '0)
    else $error("ninth cell answered");
endmodule : macro_array_chk

bind macro_array macro_array_chk #(.N_CELL(N_CELL)) i_chk (.clk_i(clk_i), .srst_i(srst_i),
  .io_o(io_o), .io_oe_o(io_oe_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o));

// file: sim/board_model.sv
// Board logic on the two-way pins.
// Assumes the bench hands it what the board wants on each line.
`timescale 1ns/100ps
module board_model (
  input wire logic [7:0] drv_i,
  input wire logic [7:0] io_o,
  input wire logic [7:0] io_oe_o,
  output logic [7:0] io_line_o
);
  // Board lets go of a line while the device drives it, so no contention
  always_comb
    for (int k = 0; k < 8; k++)
      io_line_o[k] = io_oe_o[k] ? io_o[k] : drv_i[k];
endmodule : board_model

// file: sim/macro_array_test.sv
// Self-checking bench for the macrocell array.
// Assumes a 25 MHz clock and board_model on the two-way pins.
`timescale 1ns/100ps
module macro_array_test;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [9:0] ded_i = 10'h000;
  logic [7:0] drv = 8'h00;
  logic [7:0] io_line;
  logic [7:0] io_o;
  logic [7:0] io_oe_o;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] got;
  int fail_count = 0;
  int checks = 0;

  initial forever #20 clk_i = ~clk_i;

  macro_array i_dut (.clk_i(clk_i), .srst_i(srst_i), .ded_i(ded_i), .io_i(io_line),
    .io_o(io_o), .io_oe_o(io_oe_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o));
  board_model i_board (.drv_i(drv), .io_o(io_o), .io_oe_o(io_oe_o), .io_line_o(io_line));

  // ---------------------------------------------------------------
  // Bus tasks and expectations
  // ---------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask : reg_rd

  task automatic cmp_reg(input logic [7:0] a, input logic [31:0] exp);
    reg_rd(a);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t reg %h got %h want %h", $time, a, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic g, input logic exp);
    checks++;
    if (g !== exp)
    begin
      fail_count++;
      $display("ERROR %0t pin got %b want %b", $time, g, exp);
    end
  endtask : cmp_pin

  function automatic logic [31:0] erased_word(input logic [7:0] a);
    return a[7] ? 32'h7F : (a[0] ? 32'hF : 32'hFFFFFFFF);
  endfunction : erased_word

  // D regs in [7:0], pin levels in [15:8], open security in [16]
  function automatic logic [31:0] exp_status(input logic [9:0] d, input logic [7:0] b);
    logic f;
    f = d[0] & ~d[1];
    return {16'h0001, 1'b1, ~f, f, d[2] ? d[0] : b[4], b[2], b[2], f, f,
      1'b0, ~f, f, d[0], b[2], 1'b0, f, f};
  endfunction : exp_status

  task automatic check_blank();
    logic [7:0] a;
    repeat (8) @(posedge clk_i);
    cmp_reg(macro_array_pkg::STATUS_ADDR, 32'h0001FF00);
    cmp_pin(&io_oe_o, 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      a = 8'($urandom_range(135));
      cmp_reg(a, erased_word(a));
    end
  endtask : check_blank

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(33));
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    check_blank();
    $display("test blank done");
    // Cells 0 and 1: d0 and not d1, one direct and one through the register
    reg_wr(8'h00, 32'h9);
    reg_wr(8'h01, 32'h0);
    reg_wr(8'h10, 32'h9);
    reg_wr(8'h11, 32'h0);
    reg_wr(8'h80, 32'h71);
    reg_wr(8'h81, 32'h68);
    // Cell 2 input with true pin feedback, cell 3 copies it
    reg_wr(8'h82, 32'h0F);
    reg_wr(8'h30, 32'h0100_0000);
    reg_wr(8'h31, 32'h0);
    reg_wr(8'h83, 32'h7D);
    // Cell 4 two-way: term 0 enables on d2, term 1 passes d0
    reg_wr(8'h40, 32'h10);
    reg_wr(8'h41, 32'h0);
    reg_wr(8'h42, 32'h1);
    reg_wr(8'h43, 32'h0);
    reg_wr(8'h84, 32'h3D);
    // Cell 5 follows the sampled sum of cell 1, cell 6 the inverted D reg of cell 0
    reg_wr(8'h50, 32'h0040_0000);
    reg_wr(8'h51, 32'h0);
    reg_wr(8'h60, 32'h0010_0000);
    reg_wr(8'h61, 32'h0);
    reg_wr(8'h85, 32'h7D);
    reg_wr(8'h86, 32'h7D);
    for (int n = 0; n < 16; n++)
    begin
      @(posedge clk_i);
      ded_i <= (n < 8) ? 10'(n) : 10'($urandom);
      drv <= 8'($urandom);
      // Registered pins need one more edge before their synced level is read back
      repeat (10) @(posedge clk_i);
      #1;
      cmp_pin(io_o[0], ded_i[0] & ~ded_i[1]);
      cmp_pin(io_o[1], ded_i[0] & ~ded_i[1]);
      cmp_pin(io_o[5], ded_i[0] & ~ded_i[1]);
      cmp_pin(io_o[6], ~(ded_i[0] & ~ded_i[1]));
      cmp_pin(io_oe_o[2], 1'b0);
      cmp_pin(io_o[3], drv[2]);
      cmp_pin(io_oe_o[4], ded_i[2]);
      if (ded_i[2])
        cmp_pin(io_o[4], ded_i[0]);
      cmp_reg(macro_array_pkg::STATUS_ADDR, exp_status(ded_i, drv));
    end
    $display("test logic done");
    reg_wr(8'h80, 32'hFFFFFFFF);
    cmp_reg(8'h80, 32'h71);
    reg_wr(macro_array_pkg::SEC_ADDR, 32'h0);
    cmp_reg(8'h00, 32'h0);
    cmp_reg(8'h84, 32'h0);
    cmp_reg(8'h88, 32'h0);
    cmp_reg(8'hA0, 32'h0);
    $display("test lock done");
    reg_wr(macro_array_pkg::ERASE_ADDR, 32'h0);
    reg_rd(macro_array_pkg::STATUS_ADDR);
    cmp_pin(got[16], 1'b1);
    reg_wr(macro_array_pkg::ERASE_ADDR, 32'h0);
    cmp_reg(8'h00, 32'hFFFFFFFF);
    check_blank();
    $display("test erase done");
    reg_wr(8'h82, 32'h0F);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    check_blank();
    $display("test reset done");
    give_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    $display("ERROR %0t run timed out", $time);
    give_verdict();
  end
endmodule : macro_array_test
